// >>> design/cmpdc_cfg.svh
`ifndef CMPDC_CFG_SVH
`define CMPDC_CFG_SVH
// Register byte offsets
`define CMPDC_OFF_VREF 12'h000
`define CMPDC_OFF_C0_CTL0 12'h004
`define CMPDC_OFF_C0_CTL1 12'h008
`define CMPDC_OFF_C0_PSEL 12'h00c
`define CMPDC_OFF_C1_CTL0 12'h010
`define CMPDC_OFF_C1_CTL1 12'h014
`define CMPDC_OFF_C1_PSEL 12'h018
`define CMPDC_OFF_INT_STAT 12'h01c
`define CMPDC_OFF_INT_MASK 12'h020
`define CMPDC_OFF_STATUS 12'h024
// Reference control fields
`define CMPDC_VREF_EN_BIT 7
`define CMPDC_VREF_RDY_BIT 6
`define CMPDC_VREF_TEMP_INDICATOR_ENABLE_BIT 5
`define CMPDC_VREF_TEMP_INDICATOR_RANGE_BIT 4
`define CMPDC_VREF_CGAIN_LSB 2
`define CMPDC_VREF_AGAIN_LSB 0
`define CMPDC_VREF_WMASK 8'hbf
// Control 0 fields
`define CMPDC_C0_ON_BIT 7
`define CMPDC_C0_POL_BIT 4
`define CMPDC_C0_SP_BIT 2
`define CMPDC_C0_HYS_BIT 1
`define CMPDC_C0_SYNC_BIT 0
`define CMPDC_C0_WMASK 8'h97
// Control 1 fields
`define CMPDC_C1_INTP_BIT 7
`define CMPDC_C1_INTN_BIT 6
`define CMPDC_C1_NCH_LSB 0
`define CMPDC_C1_WMASK 8'hc7
`define CMPDC_PSEL_WMASK 8'h07
`define CMPDC_RESET_BYTE 8'h00
`endif

// >>> design/cmpdc_pkg.sv
package cmpdc_pkg;
  localparam int NCMP = 2;
  typedef enum logic [1:0] {
    CMPDC_GAIN_OFF = 2'h0,
    CMPDC_GAIN_1X = 2'h1,
    CMPDC_GAIN_2X = 2'h2,
    CMPDC_GAIN_4X = 2'h3
  } cmpdc_gain_t;
  typedef enum logic [1:0] {
    CMPDC_PSRC_PIN,
    CMPDC_PSRC_DAC,
    CMPDC_PSRC_REF,
    CMPDC_PSRC_GND
  } cmpdc_psrc_t;
  typedef enum logic [1:0] {
    CMPDC_NSRC_PIN,
    CMPDC_NSRC_REF,
    CMPDC_NSRC_GND
  } cmpdc_nsrc_t;
  // Analog front-end controls for the reference block
  typedef struct packed {
    logic ref_enable;
    logic temp_indicator_enable;
    logic temp_indicator_range;
    cmpdc_gain_t comparator_ref_gain;
    cmpdc_gain_t adc_ref_gain;
  } cmpdc_vref_ctl_t;
  // Analog controls for one comparator
  typedef struct packed {
    logic comparator_on;
    logic speed_power_select;
    logic hysteresis_enable;
    logic pos_connect;
    cmpdc_psrc_t positive_input_select;
    logic neg_connect;
    cmpdc_nsrc_t negative_input_select;
  } cmpdc_cmp_ctl_t;
endpackage

// >>> design/cmpdc_top.sv
// Notes on behaviour
// - Reference enable bit 7 turns the fixed reference on or off.
// - Reference ready flag bit 6 is read-only and always reads one.
// - Bit 5 enables temperature indicator; bit 4 picks high or low range.
// - Comparator buffer gain bits 3-2: 11=4x, 10=2x, 01=1x, 00=off.
// - ADC buffer gain bits 1-0 use the same gain encoding.
// - Hysteresis applies only while its enable bit is set.
// - With sync set, output is latched on timer clock falling edge.
// - With a prescaler, the latch uses the prescaled timer clock.
// - Timer counts on rising edge, so capture on opposite edge avoids races.
// - Output is a timer gate source; software should enable sync then.
// - Rising and falling edge detectors set the flag when enabled.
// - Software clears the flag; an edge during the clear keeps it set.
// - Toggling polarity or on bit while disabled can trigger edges.
// - Positive select routes pin, DAC, reference or ground.
// - With on bit clear, all input selections are disconnected.
// - Negative select routes negative pin, reference or analog ground.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cmpdc_cfg.svh"
module cmpdc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator raw outputs (asynchronous)
  input wire logic [cmpdc_pkg::NCMP-1:0] cmp_raw,
  // Timer clock after prescaler, from the timer (asynchronous)
  input wire logic timer_clk_presc,
  // Analog control outputs
  output cmpdc_pkg::cmpdc_vref_ctl_t vref_ctl,
  output cmpdc_pkg::cmpdc_cmp_ctl_t [cmpdc_pkg::NCMP-1:0] cmp_ctl,
  // Timer gate sources
  output logic [cmpdc_pkg::NCMP-1:0] timer_gate_src,
  // Interrupts
  output logic [cmpdc_pkg::NCMP-1:0] comparator_int_flag,
  output logic irq
);
  import cmpdc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic cmpdc_psrc_t decode_psel(input logic [2:0] code);
    case (code)
      3'h0: decode_psel = CMPDC_PSRC_PIN;
      3'h1: decode_psel = CMPDC_PSRC_DAC;
      3'h2: decode_psel = CMPDC_PSRC_REF;
      default: decode_psel = CMPDC_PSRC_GND;
    endcase
  endfunction

  function automatic cmpdc_nsrc_t decode_nsel(input logic [2:0] code);
    case (code)
      3'h0: decode_nsel = CMPDC_NSRC_PIN;
      3'h1: decode_nsel = CMPDC_NSRC_REF;
      default: decode_nsel = CMPDC_NSRC_GND;
    endcase
  endfunction

  // Access hit on one register offset
  function automatic logic hit(input logic en, input logic [11:0] addr, input logic [11:0] off);
    hit = en && (addr == off);
  endfunction

  // Offsets of the per-comparator registers
  function automatic logic [11:0] ctl0_off(input int idx);
    ctl0_off = (idx == 0) ? `CMPDC_OFF_C0_CTL0 : `CMPDC_OFF_C1_CTL0;
  endfunction

  function automatic logic [11:0] ctl1_off(input int idx);
    ctl1_off = (idx == 0) ? `CMPDC_OFF_C0_CTL1 : `CMPDC_OFF_C1_CTL1;
  endfunction

  function automatic logic [11:0] psel_off(input int idx);
    psel_off = (idx == 0) ? `CMPDC_OFF_C0_PSEL : `CMPDC_OFF_C1_PSEL;
  endfunction

  // Reference block controls from one register byte
  function automatic cmpdc_vref_ctl_t vref_ctl_of(input logic [7:0] v);
    cmpdc_vref_ctl_t c;
    c.ref_enable = v[`CMPDC_VREF_EN_BIT];
    c.temp_indicator_enable = v[`CMPDC_VREF_TEMP_INDICATOR_ENABLE_BIT];
    c.temp_indicator_range = v[`CMPDC_VREF_TEMP_INDICATOR_RANGE_BIT];
    c.comparator_ref_gain = cmpdc_gain_t'(v[`CMPDC_VREF_CGAIN_LSB +: 2]);
    c.adc_ref_gain = cmpdc_gain_t'(v[`CMPDC_VREF_AGAIN_LSB +: 2]);
    return c;
  endfunction

  // Comparator analog controls from its three register bytes
  function automatic cmpdc_cmp_ctl_t cmp_ctl_of(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] ps);
    cmpdc_cmp_ctl_t c;
    c.comparator_on = c0[`CMPDC_C0_ON_BIT];
    c.speed_power_select = c0[`CMPDC_C0_SP_BIT];
    c.hysteresis_enable = c0[`CMPDC_C0_HYS_BIT];
    c.positive_input_select = decode_psel(ps[2:0]);
    c.negative_input_select = decode_nsel(c1[`CMPDC_C1_NCH_LSB +: 3]);
    c.pos_connect = c0[`CMPDC_C0_ON_BIT];
    c.neg_connect = c0[`CMPDC_C0_ON_BIT];
    return c;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [NCMP-1:0] raw_s1_r;
  logic [NCMP-1:0] raw_s2_r;
  logic tclk_s1_r;
  logic tclk_s2_r;
  logic tclk_s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_s1_r <= '0;
      raw_s2_r <= '0;
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
    end else begin
      raw_s1_r <= cmp_raw;
      raw_s2_r <= raw_s1_r;
      tclk_s1_r <= timer_clk_presc;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
    end
  end

  logic tclk_fall;
  assign tclk_fall = tclk_s3_r & ~tclk_s2_r;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] vref_r;
  logic [NCMP-1:0][7:0] ctl0_r;
  logic [NCMP-1:0][7:0] ctl1_r;
  logic [NCMP-1:0][7:0] psel_r;
  logic [NCMP-1:0] int_mask_r;
  logic [NCMP-1:0] flag_r;
  logic [NCMP-1:0] flag_nxt;
  logic [7:0] vref_nxt;
  logic [NCMP-1:0][7:0] ctl0_nxt;
  logic [NCMP-1:0][7:0] ctl1_nxt;
  logic [NCMP-1:0][7:0] psel_nxt;
  logic [NCMP-1:0] int_mask_nxt;

  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Zero wait states
  assign pready = 1'b1;

  logic addr_ok;
  always_comb begin
    unique case (paddr)
      `CMPDC_OFF_VREF, `CMPDC_OFF_C0_CTL0, `CMPDC_OFF_C0_CTL1, `CMPDC_OFF_C0_PSEL,
      `CMPDC_OFF_C1_CTL0, `CMPDC_OFF_C1_CTL1, `CMPDC_OFF_C1_PSEL,
      `CMPDC_OFF_INT_STAT, `CMPDC_OFF_INT_MASK, `CMPDC_OFF_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // ----------------------------------------
  // Register write merge
  // ----------------------------------------
  always_comb begin
    vref_nxt = vref_r;
    if (hit(wr_en, paddr, `CMPDC_OFF_VREF)) begin
      vref_nxt = pwdata[7:0] & `CMPDC_VREF_WMASK;
    end
  end

  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      ctl0_nxt[i] = ctl0_r[i];
      ctl1_nxt[i] = ctl1_r[i];
      psel_nxt[i] = psel_r[i];
      if (hit(wr_en, paddr, ctl0_off(i))) begin
        ctl0_nxt[i] = pwdata[7:0] & `CMPDC_C0_WMASK;
      end
      if (hit(wr_en, paddr, ctl1_off(i))) begin
        ctl1_nxt[i] = pwdata[7:0] & `CMPDC_C1_WMASK;
      end
      if (hit(wr_en, paddr, psel_off(i))) begin
        psel_nxt[i] = pwdata[7:0] & `CMPDC_PSEL_WMASK;
      end
    end
  end

  always_comb begin
    int_mask_nxt = int_mask_r;
    if (hit(wr_en, paddr, `CMPDC_OFF_INT_MASK)) begin
      int_mask_nxt = pwdata[NCMP-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_r <= `CMPDC_RESET_BYTE;
    end else begin
      vref_r <= vref_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_r <= '0;
    end else begin
      ctl0_r <= ctl0_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= '0;
    end else begin
      ctl1_r <= ctl1_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel_r <= '0;
    end else begin
      psel_r <= psel_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_r <= '0;
    end else begin
      int_mask_r <= int_mask_nxt;
    end
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  // Loaded from the merged next values, so they change at the same edge as the registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vref_ctl <= '0;
    end else begin
      vref_ctl <= vref_ctl_of(vref_nxt);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ctl <= '0;
    end else begin
      for (int i = 0; i < NCMP; i++) begin
        cmp_ctl[i] <= cmp_ctl_of(ctl0_nxt[i], ctl1_nxt[i], psel_nxt[i]);
      end
    end
  end

  // ----------------------------------------
  // Comparator output path
  // ----------------------------------------
  logic [NCMP-1:0] cmp_out;
  logic [NCMP-1:0] cmp_out_d_r;
  logic [NCMP-1:0] sync_lat_r;

  // off gives zero, polarity still applies
  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      cmp_out[i] = (raw_s2_r[i] & ctl0_r[i][`CMPDC_C0_ON_BIT]) ^ ctl0_r[i][`CMPDC_C0_POL_BIT];
    end
  end

  // timer clock is the prescaled one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_lat_r <= '0;
    end else if (tclk_fall) begin
      sync_lat_r <= cmp_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_gate_src <= '0;
    end else begin
      for (int i = 0; i < NCMP; i++) begin
        timer_gate_src[i] <= ctl0_r[i][`CMPDC_C0_SYNC_BIT] ? sync_lat_r[i] : cmp_out[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out_d_r <= '0;
    end else begin
      cmp_out_d_r <= cmp_out;
    end
  end

  // ----------------------------------------
  // Edge detect and flags
  // ----------------------------------------
  logic [NCMP-1:0] rise_hit;
  logic [NCMP-1:0] fall_hit;
  logic [NCMP-1:0] edge_hit;
  logic stat_rd;
  assign stat_rd = rd_en && paddr == `CMPDC_OFF_INT_STAT;

  always_comb begin
    for (int i = 0; i < NCMP; i++) begin
      rise_hit[i] = cmp_out[i] & ~cmp_out_d_r[i] & ctl1_r[i][`CMPDC_C1_INTP_BIT];
      fall_hit[i] = ~cmp_out[i] & cmp_out_d_r[i] & ctl1_r[i][`CMPDC_C1_INTN_BIT];
      edge_hit[i] = rise_hit[i] | fall_hit[i];
      flag_nxt[i] = edge_hit[i] | (flag_r[i] & ~stat_rd);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign comparator_int_flag = flag_r;
  assign irq = |(flag_r & int_mask_r);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      unique case (paddr)
        `CMPDC_OFF_VREF: prdata[7:0] <= vref_r | (8'h01 << `CMPDC_VREF_RDY_BIT);
        `CMPDC_OFF_C0_CTL0: prdata[7:0] <= ctl0_r[0];
        `CMPDC_OFF_C0_CTL1: prdata[7:0] <= ctl1_r[0];
        `CMPDC_OFF_C0_PSEL: prdata[7:0] <= psel_r[0];
        `CMPDC_OFF_C1_CTL0: prdata[7:0] <= ctl0_r[1];
        `CMPDC_OFF_C1_CTL1: prdata[7:0] <= ctl1_r[1];
        `CMPDC_OFF_C1_PSEL: prdata[7:0] <= psel_r[1];
        `CMPDC_OFF_INT_STAT: prdata[NCMP-1:0] <= flag_nxt;
        `CMPDC_OFF_INT_MASK: prdata[NCMP-1:0] <= int_mask_r;
        `CMPDC_OFF_STATUS: prdata[NCMP-1:0] <= timer_gate_src;
        default: prdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/cmpdc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cmpdc_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Comparator side
  input wire logic [cmpdc_pkg::NCMP-1:0] cmp_raw,
  input wire logic timer_clk_presc,
  input wire cmpdc_pkg::cmpdc_vref_ctl_t vref_ctl,
  input wire cmpdc_pkg::cmpdc_cmp_ctl_t [cmpdc_pkg::NCMP-1:0] cmp_ctl,
  input wire logic [cmpdc_pkg::NCMP-1:0] timer_gate_src,
  input wire logic [cmpdc_pkg::NCMP-1:0] comparator_int_flag,
  input wire logic irq
);
  import cmpdc_pkg::*;
  logic [31:0] wd_q;
  logic acc;
  logic wr;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // Write data as seen at the access edge
  always_ff @(posedge pclk) begin
    wd_q <= pwdata;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_vref_bits: assert property (wr && paddr == 12'h000 |=>
    {vref_ctl.ref_enable, vref_ctl.temp_indicator_enable, vref_ctl.temp_indicator_range} == {wd_q[7], wd_q[5:4]})
    else $error("reference enable bits wrong");
  chk_gain_sel: assert property (wr && paddr == 12'h000 |=>
    {vref_ctl.comparator_ref_gain, vref_ctl.adc_ref_gain} == wd_q[3:0]) else $error("gain fields wrong");
  chk_ready_reads: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[6])
    else $error("ready flag read as zero");
  chk_ctl0_hys: assert property (wr && paddr == 12'h004 |=>
    cmp_ctl[0].hysteresis_enable == wd_q[1] && cmp_ctl[0].comparator_on == wd_q[7]) else $error("ctl0 fields wrong");
  chk_pos_map: assert property (wr && paddr == 12'h00c |=>
    cmp_ctl[0].positive_input_select == (wd_q[2:0] > 3'h3 ? CMPDC_PSRC_GND : cmpdc_psrc_t'(wd_q[1:0])))
    else $error("positive select wrong");
  chk_neg_map: assert property (wr && paddr == 12'h008 |=>
    cmp_ctl[0].negative_input_select == (wd_q[2:0] == 3'h0 ? CMPDC_NSRC_PIN :
    wd_q[2:0] == 3'h1 ? CMPDC_NSRC_REF : CMPDC_NSRC_GND)) else $error("negative select wrong");
  chk_off_disc: assert property (!cmp_ctl[0].comparator_on |->
    !cmp_ctl[0].pos_connect && !cmp_ctl[0].neg_connect) else $error("inputs connected while off");
  chk_flag_sticky: assert property (comparator_int_flag[0] &&
    !(acc && !pwrite && paddr == 12'h01c) |=> comparator_int_flag[0]) else $error("flag lost without clear");
  chk_irq_quiet: assert property (comparator_int_flag == 2'h0 |-> !irq) else $error("irq without flag");
  chk_unmapped_err: assert property (acc && paddr > 12'h024 |-> pslverr && pready) else $error("no error response");
  cover property (comparator_int_flag[1] ##1 irq);
  cover property (acc && pslverr);
  cover property ($rose(timer_gate_src[0]));
endmodule
bind cmpdc_top cmpdc_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmp_raw(cmp_raw), .timer_clk_presc(timer_clk_presc), .vref_ctl(vref_ctl), .cmp_ctl(cmp_ctl),
  .timer_gate_src(timer_gate_src), .comparator_int_flag(comparator_int_flag), .irq(irq));
`default_nettype wire

// >>> tb/cmpdc_timer_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmpdc_timer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer side
  input wire logic run,
  input wire logic gate,
  output var logic tclk,
  output var logic [15:0] ticks
);
  logic [1:0] div_r;
  // prescaled clock, starts high after reset and holds its last level between bursts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      tclk <= 1'b1;
    end else if (run) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        tclk <= ~tclk;
      end
    end
  end
  // count on rising edge while gated
  always_ff @(posedge tclk or negedge presetn) begin
    if (!presetn) begin
      ticks <= 16'h0;
    end else if (gate) begin
      ticks <= ticks + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_comparator_digital_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_comparator_digital_control;
  import cmpdc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tclk, run, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cmp_raw, gsrc, flag;
  logic [15:0] ticks;
  logic [7:0] w;
  logic [7:0] corner [4] = '{8'hff, 8'h00, 8'h96, 8'h29};
  cmpdc_vref_ctl_t vref_ctl;
  cmpdc_cmp_ctl_t [1:0] cmp_ctl;
  integer seed = 32'hdbf7;
  int mismatches, n_tests, i;
  cmpdc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .timer_clk_presc(tclk), .vref_ctl(vref_ctl), .cmp_ctl(cmp_ctl), .timer_gate_src(gsrc),
    .comparator_int_flag(flag), .irq(irq));
  cmpdc_timer_model tm_u (.pclk(pclk), .presetn(presetn), .run(run), .gate(gsrc[0]), .tclk(tclk), .ticks(ticks));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] pexp(input int c);
    return c > 3 ? 32'h3 : 32'(c);
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("[ERR] %s exp %h got %h", n, x, g);
      mismatches++;
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wt;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(40 * 6000);
    mismatches++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmp_raw, run, presetn} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset", i == 0 ? 32'h40 : 32'h0, rd);
    end
    for (i = 0; i < 12; i++) begin
      w = i < 4 ? corner[i] : 8'($random(seed));
      apb(1'b1, 12'h000, {24'h0, w});
      apb(1'b0, 12'h000, 32'h0);
      chk("vref_rd", {24'h0, w & 8'hbf | 8'h40}, rd);
      chk("vref_ctl", {25'h0, w[7], w[5:0]}, 32'(vref_ctl));
    end
    apb(1'b1, 12'h004, 32'h80);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 12'h00c, 32'(i));
      apb(1'b1, 12'h008, 32'(i));
      chk("psel", pexp(i), 32'(cmp_ctl[0].positive_input_select));
      chk("nsel", i > 1 ? 32'h2 : 32'(i), 32'(cmp_ctl[0].negative_input_select));
    end
    chk("conn_on", 32'h3, {30'h0, cmp_ctl[0].pos_connect, cmp_ctl[0].neg_connect});
    apb(1'b1, 12'h004, 32'h06);
    chk("conn_off", 32'h0, {30'h0, cmp_ctl[0].pos_connect, cmp_ctl[0].neg_connect});
    chk("hys_sp", 32'h3, {30'h0, cmp_ctl[0].speed_power_select, cmp_ctl[0].hysteresis_enable});
    apb(1'b1, 12'h028, 32'hff);
    chk("slverr_w", 32'h1, 32'(e));
    apb(1'b0, 12'h028, 32'h0);
    chk("unmapped", 32'h1, {31'(rd), e});
    apb(1'b1, 12'h010, 32'h80);
    chk("c1_on", 32'h3, {30'h0, cmp_ctl[1].comparator_on, cmp_ctl[1].pos_connect});
    apb(1'b1, 12'h014, 32'h80);
    apb(1'b1, 12'h020, 32'h2);
    @(posedge pclk) cmp_raw <= 2'b10;
    wt();
    chk("rise_flag", 32'h2, {30'h0, flag});
    chk("irq_on", 32'h1, 32'(irq));
    chk("gate_async", 32'h1, {31'h0, gsrc[1]});
    apb(1'b0, 12'h01c, 32'h0);
    chk("stat", 32'h2, rd);
    chk("cleared", 32'h0, {30'h0, flag});
    @(posedge pclk) cmp_raw <= 2'b00;
    wt();
    chk("fall_off", 32'h0, {30'h0, flag});
    // Edge reaches the flag at the very access edge of the clearing read
    @(posedge pclk) cmp_raw <= 2'b10;
    apb(1'b0, 12'h01c, 32'h0);
    chk("race_keep", 32'h2, {30'h0, flag});
    apb(1'b0, 12'h01c, 32'h0);
    chk("race_stat", 32'h2, rd);
    chk("race_clr", 32'h0, {30'h0, flag});
    apb(1'b1, 12'h008, 32'h80);
    apb(1'b1, 12'h004, 32'h10);
    wt();
    chk("pol_flag", 32'h1, {30'h0, flag});
    chk("irq_mask", 32'h0, 32'(irq));
    apb(1'b1, 12'h004, 32'h81);
    @(posedge pclk) cmp_raw <= 2'b01;
    wt();
    chk("gate_hold", 32'h0, {31'h0, gsrc[0]});
    @(posedge pclk) run <= 1'b1;
    repeat (5) wt();
    chk("gate_sync", 32'h1, {31'h0, gsrc[0]});
    chk("ticks", 32'h1, 32'(ticks != 16'h0));
    apb(1'b0, 12'h024, 32'h0);
    chk("status", 32'h1, rd);
    close_out();
  end
endmodule
`default_nettype wire
